// ==== hdl/csc_regs.sv ====
// Purpose: Configuration registers for the clock synthesizer and lane drivers
// Assumes: Serial control port decoder presents byte writes and reads
// Notes:   Read data appears one cycle after the read strobe
// Behaviour
// [R1] Reference output follows enable bit and pin
// [R2] Reference enable bit resets to one
// [R3] Software writes reserved bits with reset values
// [R4] Second divider: codes divide 1, 2, 4
// [R5] First divider: codes divide 5, 4, 3
// [R6] Third divider divides by its value
// [R7] Software asserts synth reset before divider change
// [R8] Software programs bias 0x4A before use
// [R9] One pre-emphasis value drives all lanes
// [R10] Registers read back last write, reset cleanly
`timescale 1ns/1ps

// Register map, every register one byte wide
//   0x3c reference_output_control, resets to 0x01
//        bit 0 ref_out_enable, bits 7:1 reserved
//   0x3d feedback_divider_first_second, resets to 0x00
//        bits 1:0 first code, bits 3:2 second code, bits 7:4 reserved
//   0x3e feedback_divider_third, resets to 0x20
//        bits 5:0 third value, bits 7:6 reserved
//   0x3f oscillator_bias_control, resets to 0x4f
//        bits 6:0 oscillator_bias_level, bit 7 reserved
//   0x48 lane_preemphasis_control, resets to 0x00
//        bits 3:0 lane_preemphasis, bits 7:4 reserved
//
// Timing
//   A write lands at its strobe edge
//   Ratios, gated output and lanes follow one edge later
//   Bias level follows its register with no extra stage
//   Read data and valid pulse come one edge after the strobe
//   Read and write in one cycle return the old byte
//   Lane outputs carry one copy of the setting each
//
// Hazards
//   Reference output may clock the control port, so its enable bit starts at one; the output itself is low in reset
//   Divider controls change live; software must hold the synth in reset
//   Divider values are applied even when flagged unsafe
//   Reserved divider codes are not blocked, they raise the invalid flag
//   Unmapped writes are dropped, unmapped reads return zero

module csc_regs
    import csc_pkg::*;
#(
    parameter int LANES = CSC_LANES
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       resetn,
    // Byte register port
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    input  wire logic [CSC_ADDR_W-1:0]      reg_addr,
    input  wire logic [CSC_DATA_W-1:0]      reg_wdata,
    output logic      [CSC_DATA_W-1:0]      reg_rdata,
    output logic                            reg_rvalid,
    // Synthesizer pins
    input  wire logic                       synth_enable,
    input  wire logic                       synth_reset_control,
    // Controls toward the synthesizer
    output logic                            reference_clock_output,
    output logic      [CSC_RATIO_W-1:0]     first_div_ratio,
    output logic      [CSC_RATIO_W-1:0]     second_div_ratio,
    output logic      [CSC_DIV3_W-1:0]      third_div_ratio,
    output logic                            div_setting_invalid,
    output logic                            div_change_unsafe,
    // Analog and lane settings
    output logic      [CSC_BIAS_W-1:0]      oscillator_bias_level,
    output logic      [LANES*CSC_PE_W-1:0]  lane_preemphasis
);

    // Stored registers, all eight bits kept
    logic [CSC_DATA_W-1:0] ref_out_q;   // reference_output_control
    logic [CSC_DATA_W-1:0] ref_out_d;   // Next reference control byte
    logic [CSC_DATA_W-1:0] fbdiv12_q;   // feedback_divider_first_second
    logic [CSC_DATA_W-1:0] fbdiv12_d;   // Next first and second codes
    logic [CSC_DATA_W-1:0] fbdiv3_q;    // feedback_divider_third
    logic [CSC_DATA_W-1:0] fbdiv3_d;    // Next third value byte
    logic [CSC_DATA_W-1:0] bias_q;      // oscillator_bias_control
    logic [CSC_DATA_W-1:0] bias_d;      // Next bias byte
    logic [CSC_DATA_W-1:0] lane_pe_q;   // lane_preemphasis_control
    logic [CSC_DATA_W-1:0] lane_pe_d;   // Next pre-emphasis byte
    // Read path
    logic [CSC_DATA_W-1:0] rdata_q;     // Last read byte, held
    logic [CSC_DATA_W-1:0] rdata_d;     // Next read byte
    logic                  rvalid_q;    // Read answer pulse
    logic                  rvalid_d;    // Next answer pulse
    // Divider write seen outside synth reset
    logic                  unsafe_q;    // Sticky diagnostic flag
    logic                  unsafe_d;    // Next flag value
    logic                  div_wr;      // Divider register written now

    // Settings bundle between the two stages
    csc_cfg_if #(.LANES(LANES)) cfg ();

    // Write decode and next register values
    always_comb begin
        // Hold every register by default
        ref_out_d = ref_out_q;
        fbdiv12_d = fbdiv12_q;
        fbdiv3_d  = fbdiv3_q;
        bias_d    = bias_q;
        lane_pe_d = lane_pe_q;
        div_wr    = 1'b0;
        // Only a write strobe changes stored state
        if (reg_wr) begin
            // [R10] whole byte stored, reserved too
            unique case (reg_addr)
                // Reference enable byte
                CSC_OFF_REF_OUT:  ref_out_d = reg_wdata;
                // First and second divider codes
                CSC_OFF_FBDIV12: begin
                    fbdiv12_d = reg_wdata;
                    div_wr    = 1'b1;
                end
                // Third divider value
                CSC_OFF_FBDIV3: begin
                    fbdiv3_d = reg_wdata;
                    div_wr   = 1'b1;
                end
                // Oscillator bias byte
                CSC_OFF_OSC_BIAS: bias_d    = reg_wdata;
                // Lane pre-emphasis byte
                CSC_OFF_LANE_PE:  lane_pe_d = reg_wdata;
                default:          ;  // Unmapped write ignored
            endcase
        end
        // Sticky until reset, values still applied
        // [R7] flag divider change outside reset
        unsafe_d = unsafe_q | (div_wr & ~synth_reset_control);
    end

    // Read mux
    // Read and write in one cycle return the old byte
    always_comb begin
        // Valid pulse follows the strobe
        rvalid_d = reg_rd;
        // Data holds between reads
        rdata_d  = rdata_q;
        // Only a read strobe loads new data
        if (reg_rd) begin
            unique case (reg_addr)
                CSC_OFF_REF_OUT:  rdata_d = ref_out_q;
                CSC_OFF_FBDIV12:  rdata_d = fbdiv12_q;
                CSC_OFF_FBDIV3:   rdata_d = fbdiv3_q;
                CSC_OFF_OSC_BIAS: rdata_d = bias_q;
                CSC_OFF_LANE_PE:  rdata_d = lane_pe_q;
                default:          rdata_d = CSC_RD_UNMAPPED;
            endcase
        end
    end

    // Register state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // Async reset to listed values
            // [R2] reference enable starts at one
            ref_out_q <= CSC_RST_REF_OUT;
            // [R10] listed reset values
            fbdiv12_q <= CSC_RST_FBDIV12;
            fbdiv3_q  <= CSC_RST_FBDIV3;
            bias_q    <= CSC_RST_OSC_BIAS;
            lane_pe_q <= CSC_RST_LANE_PE;
            // Read path idle, diagnostic clear
            rdata_q   <= CSC_RD_UNMAPPED;
            rvalid_q  <= 1'b0;
            unsafe_q  <= 1'b0;
        end else begin
            // Take the next values
            ref_out_q <= ref_out_d;
            fbdiv12_q <= fbdiv12_d;
            fbdiv3_q  <= fbdiv3_d;
            bias_q    <= bias_d;
            lane_pe_q <= lane_pe_d;
            rdata_q   <= rdata_d;
            rvalid_q  <= rvalid_d;
            unsafe_q  <= unsafe_d;
        end
    end

    // Field extraction toward the apply stage
    // Reserved bits stay here, only fields go on
    // Reference enable bit
    assign cfg.ref_en     = ref_out_q[CSC_REF_EN_BIT];
    // First divider code
    assign cfg.div1_code  = fbdiv12_q[CSC_DIV1_LSB +: CSC_DIV1_W];
    // Second divider code
    assign cfg.div2_code  = fbdiv12_q[CSC_DIV2_LSB +: CSC_DIV2_W];
    // Third divider value
    assign cfg.div3_value = fbdiv3_q[CSC_DIV3_LSB +: CSC_DIV3_W];
    // Global pre-emphasis setting
    assign cfg.pe_setting = lane_pe_q[CSC_PE_LSB +: CSC_PE_W];

    // Decode and gating stage
    // Ratios, invalid flag, gated output and lanes are flops there
    csc_apply #(
        .LANES        (LANES)
    ) u_apply (
        .clk          (clk),
        .resetn       (resetn),
        .synth_enable (synth_enable),
        .cfg          (cfg)
    );

    // Outputs, each from a flop
    // Register port answers
    assign reg_rdata              = rdata_q;
    assign reg_rvalid             = rvalid_q;
    // Synthesizer controls from the apply stage
    assign reference_clock_output = cfg.ref_drive;
    assign first_div_ratio        = cfg.div1_ratio;
    assign second_div_ratio       = cfg.div2_ratio;
    assign third_div_ratio        = cfg.div3_ratio;
    assign div_setting_invalid    = cfg.div_bad;
    // Diagnostic and bias straight from this stage
    assign div_change_unsafe      = unsafe_q;
    assign oscillator_bias_level  = bias_q[CSC_BIAS_LSB +: CSC_BIAS_W];
    // Lanes from the apply stage
    assign lane_preemphasis       = cfg.lane_pe;

endmodule // csc_regs

// ==== inc/csc_pkg.sv ====
// Purpose: Constants for the clock synthesizer configuration slice
// Assumes: Byte-wide registers at their printed byte offsets
// Notes:   Shared by the register slice, its apply stage and the interface
package csc_pkg;

    // Register access widths
    localparam int          CSC_ADDR_W       = 15;
    localparam int          CSC_DATA_W       = 8;

    // Register offsets
    localparam logic [14:0] CSC_OFF_REF_OUT  = 15'h003c;  // reference_output_control
    localparam logic [14:0] CSC_OFF_FBDIV12  = 15'h003d;  // feedback_divider_first_second
    localparam logic [14:0] CSC_OFF_FBDIV3   = 15'h003e;  // feedback_divider_third
    localparam logic [14:0] CSC_OFF_OSC_BIAS = 15'h003f;  // oscillator_bias_control
    localparam logic [14:0] CSC_OFF_LANE_PE  = 15'h0048;  // lane_preemphasis_control

    // Reset values
    localparam logic [7:0]  CSC_RST_REF_OUT  = 8'h01;
    localparam logic [7:0]  CSC_RST_FBDIV12  = 8'h00;
    localparam logic [7:0]  CSC_RST_FBDIV3   = 8'h20;
    localparam logic [7:0]  CSC_RST_OSC_BIAS = 8'h4f;
    localparam logic [7:0]  CSC_RST_LANE_PE  = 8'h00;
    localparam logic [7:0]  CSC_RD_UNMAPPED  = 8'h00;

    // Field positions
    localparam int          CSC_REF_EN_BIT   = 0;
    localparam int          CSC_DIV1_LSB     = 0;
    localparam int          CSC_DIV1_W       = 2;
    localparam int          CSC_DIV2_LSB     = 2;
    localparam int          CSC_DIV2_W       = 2;
    localparam int          CSC_DIV3_LSB     = 0;
    localparam int          CSC_DIV3_W       = 6;
    localparam int          CSC_BIAS_LSB     = 0;
    localparam int          CSC_BIAS_W       = 7;
    localparam int          CSC_PE_LSB       = 0;
    localparam int          CSC_PE_W         = 4;

    // Divider codes and ratios
    localparam int          CSC_RATIO_W      = 3;
    localparam logic [1:0]  CSC_CODE_0       = 2'h0;
    localparam logic [1:0]  CSC_CODE_1       = 2'h1;
    localparam logic [1:0]  CSC_CODE_2       = 2'h2;
    localparam logic [2:0]  CSC_DIV1_R0      = 3'h5;
    localparam logic [2:0]  CSC_DIV1_R1      = 3'h4;
    localparam logic [2:0]  CSC_DIV1_R2      = 3'h3;
    localparam logic [2:0]  CSC_DIV2_R0      = 3'h1;
    localparam logic [2:0]  CSC_DIV2_R1      = 3'h2;
    localparam logic [2:0]  CSC_DIV2_R2      = 3'h4;
    localparam logic [2:0]  CSC_RATIO_NONE   = 3'h0;
    localparam logic [5:0]  CSC_DIV3_ZERO    = 6'h00;

    // Serializer lanes
    localparam int          CSC_LANES        = 8;

endpackage

// ==== inc/csc_cfg_if.sv ====
// Purpose: Carries settings from the register slice to its apply stage
// Assumes: One clock domain
// Notes:   Settings flow one way, applied values flow back
`timescale 1ns/1ps
interface csc_cfg_if #(
    parameter int LANES = csc_pkg::CSC_LANES
);
    import csc_pkg::*;
    logic                       ref_en;       // Stored reference output enable
    logic [CSC_DIV1_W-1:0]      div1_code;    // First divider code
    logic [CSC_DIV2_W-1:0]      div2_code;    // Second divider code
    logic [CSC_DIV3_W-1:0]      div3_value;   // Third divider value
    logic [CSC_PE_W-1:0]        pe_setting;   // Global pre-emphasis
    logic                       ref_drive;    // Reference output driven
    logic [CSC_RATIO_W-1:0]     div1_ratio;   // Decoded first ratio
    logic [CSC_RATIO_W-1:0]     div2_ratio;   // Decoded second ratio
    logic [CSC_DIV3_W-1:0]      div3_ratio;   // Applied third ratio
    logic                       div_bad;      // Reserved or zero divider
    logic [LANES*CSC_PE_W-1:0]  lane_pe;      // Per-lane pre-emphasis

    // Register side
    modport regs  (output ref_en, div1_code, div2_code, div3_value, pe_setting,
                   input  ref_drive, div1_ratio, div2_ratio, div3_ratio, div_bad, lane_pe);
    // Apply side
    modport apply (input  ref_en, div1_code, div2_code, div3_value, pe_setting,
                   output ref_drive, div1_ratio, div2_ratio, div3_ratio, div_bad, lane_pe);
endinterface

// ==== hdl/csc_apply.sv ====
// Purpose: Turns stored settings into registered controls for the synthesizer
// Assumes: Pin inputs synchronous to clk
// Notes:   All outputs are flops so the top drives them straight out
`timescale 1ns/1ps
module csc_apply
    import csc_pkg::*;
#(
    parameter int LANES = CSC_LANES
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic synth_enable,
    csc_cfg_if.apply  cfg
);

    // Next values
    logic                       ref_drive_d;
    logic [CSC_RATIO_W-1:0]     div1_ratio_d;
    logic [CSC_RATIO_W-1:0]     div2_ratio_d;
    logic                       div_bad_d;
    logic [LANES*CSC_PE_W-1:0]  lane_pe_d;
    logic [CSC_DIV3_W-1:0]      div3_ratio_d;
    // Registered values
    logic                       ref_drive_q;
    logic [CSC_RATIO_W-1:0]     div1_ratio_q;
    logic [CSC_RATIO_W-1:0]     div2_ratio_q;
    logic [CSC_DIV3_W-1:0]      div3_ratio_q;
    logic                       div_bad_q;
    logic [LANES*CSC_PE_W-1:0]  lane_pe_q;

    // Decode controls from settings
    always_comb begin
        // [R1] output gated by enable pin
        ref_drive_d = cfg.ref_en & synth_enable;
        // [R5] first divider ratio decode
        unique case (cfg.div1_code)
            CSC_CODE_0: div1_ratio_d = CSC_DIV1_R0;
            CSC_CODE_1: div1_ratio_d = CSC_DIV1_R1;
            CSC_CODE_2: div1_ratio_d = CSC_DIV1_R2;
            default:    div1_ratio_d = CSC_RATIO_NONE;  // Reserved code
        endcase
        // [R4] second divider ratio decode
        unique case (cfg.div2_code)
            CSC_CODE_0: div2_ratio_d = CSC_DIV2_R0;
            CSC_CODE_1: div2_ratio_d = CSC_DIV2_R1;
            CSC_CODE_2: div2_ratio_d = CSC_DIV2_R2;
            default:    div2_ratio_d = CSC_RATIO_NONE;  // Reserved code
        endcase
        // [R6] zero third value unsupported
        div_bad_d = (div1_ratio_d == CSC_RATIO_NONE) | (div2_ratio_d == CSC_RATIO_NONE)
                  | (cfg.div3_value == CSC_DIV3_ZERO);
        // [R6] value is the ratio
        div3_ratio_d = cfg.div3_value;
    end

    // [R9] one setting to all lanes
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        assign lane_pe_d[l*CSC_PE_W +: CSC_PE_W] = cfg.pe_setting;
    end

    // Register the controls
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ref_drive_q  <= 1'b0;
            div1_ratio_q <= CSC_DIV1_R0;
            div2_ratio_q <= CSC_DIV2_R0;
            div3_ratio_q <= CSC_RST_FBDIV3[CSC_DIV3_LSB +: CSC_DIV3_W];
            div_bad_q    <= 1'b0;
            lane_pe_q    <= '0;
        end else begin
            ref_drive_q  <= ref_drive_d;
            div1_ratio_q <= div1_ratio_d;
            div2_ratio_q <= div2_ratio_d;
            div3_ratio_q <= div3_ratio_d;
            div_bad_q    <= div_bad_d;
            lane_pe_q    <= lane_pe_d;
        end
    end

    assign cfg.ref_drive  = ref_drive_q;
    assign cfg.div1_ratio = div1_ratio_q;
    assign cfg.div2_ratio = div2_ratio_q;
    assign cfg.div3_ratio = div3_ratio_q;
    assign cfg.div_bad    = div_bad_q;
    assign cfg.lane_pe    = lane_pe_q;

endmodule // csc_apply

// ==== dv/csc_regs_properties.sv ====
// Purpose: Port checks of the configuration slice
// Assumes: One clock, async active-low reset
// Notes:   Bound into every csc_regs instance
`timescale 1ns/1ps
module csc_regs_properties
    import csc_pkg::*;
#(
    parameter int LANES = CSC_LANES
) (
    input wire logic                      clk,
    input wire logic                      resetn,
    input wire logic                      reg_wr,
    input wire logic                      reg_rd,
    input wire logic [CSC_ADDR_W-1:0]     reg_addr,
    input wire logic [CSC_DATA_W-1:0]     reg_wdata,
    input wire logic                      reg_rvalid,
    input wire logic                      synth_enable,
    input wire logic                      synth_reset_control,
    input wire logic                      reference_clock_output,
    input wire logic [CSC_RATIO_W-1:0]    first_div_ratio,
    input wire logic [CSC_RATIO_W-1:0]    second_div_ratio,
    input wire logic [CSC_DIV3_W-1:0]     third_div_ratio,
    input wire logic                      div_setting_invalid,
    input wire logic                      div_change_unsafe,
    input wire logic [CSC_BIAS_W-1:0]     oscillator_bias_level,
    input wire logic [LANES*CSC_PE_W-1:0] lane_preemphasis
);
    logic ref_bit_q;  // Shadow of the stored enable bit
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Ratio tables of the two small dividers
    function automatic logic [2:0] d1(logic [1:0] c);
        return (c == 2'h0) ? 3'h5 : (c == 2'h1) ? 3'h4 : (c == 2'h2) ? 3'h3 : 3'h0;
    endfunction
    function automatic logic [2:0] d2(logic [1:0] c);
        return (c == 2'h0) ? 3'h1 : (c == 2'h1) ? 3'h2 : (c == 2'h2) ? 3'h4 : 3'h0;
    endfunction
    // Shadow follows writes to the enable register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            ref_bit_q <= 1'b1;
        else if (reg_wr && reg_addr == CSC_OFF_REF_OUT)
            ref_bit_q <= reg_wdata[0];
    end
    sequence s_wr(logic [14:0] a);
        reg_wr && reg_addr == a;
    endsequence
    chk_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read without answer");
    chk_rvalid_pulse: assert property (!reg_rd |=> !reg_rvalid)
        else $error("answer without read");
    chk_ref_follow: assert property (
        $past(resetn) |-> reference_clock_output == $past(ref_bit_q && synth_enable))
        else $error("reference output wrong");
    chk_bias_direct: assert property (
        s_wr(CSC_OFF_OSC_BIAS) |=> oscillator_bias_level == $past(reg_wdata[6:0]))
        else $error("bias level wrong");
    chk_first_div: assert property (
        s_wr(CSC_OFF_FBDIV12) |-> ##2 first_div_ratio == d1($past(reg_wdata[1:0], 2)))
        else $error("first ratio wrong");
    chk_second_div: assert property (
        s_wr(CSC_OFF_FBDIV12) |-> ##2 second_div_ratio == d2($past(reg_wdata[3:2], 2)))
        else $error("second ratio wrong");
    chk_third_div: assert property (
        s_wr(CSC_OFF_FBDIV3) |-> ##2 third_div_ratio == $past(reg_wdata[5:0], 2))
        else $error("third ratio wrong");
    chk_lane_copy: assert property (
        s_wr(CSC_OFF_LANE_PE) |-> ##2 lane_preemphasis == {LANES{$past(reg_wdata[3:0], 2)}})
        else $error("lane setting wrong");
    chk_div_invalid: assert property (
        div_setting_invalid == (first_div_ratio == 3'h0 || second_div_ratio == 3'h0
                                || third_div_ratio == 6'h00))
        else $error("invalid flag wrong");
    chk_unsafe_set: assert property (
        reg_wr && !synth_reset_control
        && (reg_addr == CSC_OFF_FBDIV12 || reg_addr == CSC_OFF_FBDIV3)
        |-> ##[1:2] div_change_unsafe)
        else $error("unsafe flag not set");
    chk_unsafe_hold: assert property (div_change_unsafe |=> div_change_unsafe)
        else $error("unsafe flag dropped");
endmodule // csc_regs_properties

bind csc_regs csc_regs_properties #(.LANES(LANES)) chk_u (.clk, .resetn, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rvalid, .synth_enable, .synth_reset_control,
    .reference_clock_output, .first_div_ratio, .second_div_ratio, .third_div_ratio,
    .div_setting_invalid, .div_change_unsafe, .oscillator_bias_level, .lane_preemphasis);

// ==== dv/tb_csc_regs.sv ====
// Purpose: Directed register tests of the configuration slice
// Assumes: Inputs change on the falling edge
// Notes:   Expected values come from local tables
`timescale 1ns/1ps
module tb_csc_regs;
    import csc_pkg::*;
    logic        clk;
    logic        resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        synth_enable = 1'b1, synth_reset_control = 1'b1;
    logic [14:0] reg_addr = 15'h0;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata;
    logic        reg_rvalid, reference_clock_output, div_setting_invalid, div_change_unsafe;
    logic [2:0]  first_div_ratio, second_div_ratio;
    logic [5:0]  third_div_ratio;
    logic [6:0]  oscillator_bias_level;
    logic [31:0] lane_preemphasis;
    int          error_cnt = 0, samples_checked = 0, cyc = 0;
    localparam logic [14:0] ADR [5] = '{15'h3c, 15'h3d, 15'h3e, 15'h3f, 15'h48};
    localparam logic [7:0]  RST [5] = '{8'h01, 8'h00, 8'h20, 8'h4f, 8'h00};
    localparam logic [2:0]  R1T [4] = '{3'h5, 3'h4, 3'h3, 3'h0};
    localparam logic [2:0]  R2T [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
    localparam logic [5:0]  T3  [4] = '{6'h01, 6'h3f, 6'h00, 6'h20};

    csc_regs dut_u (.clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rvalid, .synth_enable, .synth_reset_control, .reference_clock_output,
        .first_div_ratio, .second_div_ratio, .third_div_ratio, .div_setting_invalid,
        .div_change_unsafe, .oscillator_bias_level, .lane_preemphasis);

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic results;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [14:0] a, input logic [7:0] e);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        cmp(reg_rdata, e);
        cmp(reg_rvalid, 32'h1);
        @(negedge clk);
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            results();
        end
    end
    // Main sequence
    initial begin
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        cmp(reference_clock_output, 32'h1);
        cmp({first_div_ratio, second_div_ratio, third_div_ratio}, 12'ha60);
        cmp(oscillator_bias_level, 32'h4f);
        cmp(lane_preemphasis, 32'h0);
        for (int i = 0; i < 5; i++) rd(ADR[i], RST[i]);
        rd(15'h0040, 8'h00);
        for (int i = 0; i < 16; i++) begin
            wr(CSC_OFF_FBDIV12, 8'(i));
            cmp({first_div_ratio, second_div_ratio}, {R1T[i%4], R2T[i/4]});
            cmp(div_setting_invalid, 32'(i%4 == 3 || i/4 == 3));
        end
        wr(CSC_OFF_FBDIV12, 8'h00);
        foreach (T3[j]) begin
            wr(CSC_OFF_FBDIV3, {2'h0, T3[j]});
            cmp({third_div_ratio, div_setting_invalid}, {T3[j], T3[j] == 6'h00});
        end
        cmp(div_change_unsafe, 32'h0);
        synth_reset_control = 1'b0;
        wr(CSC_OFF_FBDIV3, 8'h05);
        cmp({third_div_ratio, div_change_unsafe}, {6'h05, 1'b1});
        rd(CSC_OFF_FBDIV3, 8'h05);
        wr(CSC_OFF_REF_OUT, 8'h00);
        cmp(reference_clock_output, 32'h0);
        wr(CSC_OFF_REF_OUT, 8'h01);
        synth_enable = 1'b0;
        @(negedge clk);
        cmp(reference_clock_output, 32'h0);
        synth_enable = 1'b1;
        @(negedge clk);
        cmp(reference_clock_output, 32'h1);
        wr(CSC_OFF_OSC_BIAS, 8'h4a);
        cmp(oscillator_bias_level, 32'h4a);
        wr(CSC_OFF_LANE_PE, 8'h06);
        cmp(lane_preemphasis, 32'h66666666);
        wr(15'h0040, 8'hff);
        rd(CSC_OFF_LANE_PE, 8'h06);
        resetn = 1'b0;
        @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        rd(CSC_OFF_OSC_BIAS, 8'h4f);
        cmp(div_change_unsafe, 32'h0);
        results();
    end
endmodule // tb_csc_regs
